// >>> hdl/flash_backlight_control_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) Flash time-out code sits in config bits 4:0, 32 ms per step.
// (RULE2) I/O bit 7 gates backlight overvoltage and string short flag reporting.
// (RULE3) I/O bit 0 enables supply monitor, bit 1 standby/torch, 3-bit threshold.
// (RULE4) Enable bits 6,5,4,3 switch flash outputs and backlight strings.
// (RULE5) Enable bit 0 switches backlight boost converter.
// (RULE6) Host avoids flash with both flash outputs disabled.
// (RULE7) Host avoids backlight with both strings disabled.
// (RULE8) Flag bit 4 sets when supply crosses monitor threshold.
// (RULE9) TX honoured when I/O bit 2 set, polarity bit 3; event sets flag 3.
// (RULE10) Fault flags bits 7,6,5,2,1,0 set on their faults.
// (RULE11) Flash enable clears itself when a flash event ends.
// (RULE12) Flash configuration ignores writes while flash enabled.
// (RULE13) I/O bit 4 strobe trigger, bit 5 strobe polarity, bit 6 PWM enable.
// (RULE14) Enable bit 2 flash/torch, bit 1 flash start, bit 7 software reset.
module flash_backlight_control_regs #(
  parameter int STEP_CYCLES = flash_backlight_pkg::TIMEOUT_STEP_CYCLES
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic strobe_in,
  input wire logic tx_in,
  input wire logic pwm_in,
  input wire logic supply_below_in,
  input wire logic bl_ovp_fault_in,
  input wire logic fl_ovp_fault_in,
  input wire logic fl_out_short_in,
  input wire logic fl_led_short_in,
  input wire logic bl_short_in,
  input wire logic thermal_in,
  output logic flash_output_one_en_out,
  output logic flash_output_two_en_out,
  output logic backlight_string_one_en_out,
  output logic backlight_string_two_en_out,
  output logic backlight_boost_en_out,
  output logic flash_fire_out,
  output logic torch_on_out,
  output logic tx_active_out,
  output logic pwm_out,
  output logic monitor_standby_out,
  output logic monitor_torch_out,
  output logic [flash_backlight_pkg::THR_CODE_W-1:0] threshold_code_out,
  output logic [7:0] flash_cfg_out
);
  import flash_backlight_pkg::*;

  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] thr_reg, thr_next;
  logic [7:0] io_reg, io_next;
  logic [7:0] en_reg, en_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] rdata_reg, rdata_next;
  flash_state_e state_reg, state_next;
  logic strb_act_reg, strb_act_next;
  logic tx_act_reg, tx_act_next;
  logic pwm_reg, pwm_next;
  logic mon_hit_reg, mon_hit_next;

  logic strb_act, tx_act, strb_rise, tx_event;
  logic soft_rst, wr_cfg, wr_thr, wr_io, wr_en, rd_flags;
  logic fire_start, fire_stop, flash_end;
  logic timer_done;
  logic [7:0] flag_set;

  assign wr_cfg = reg_wr_in && reg_addr_in == OFS_FLASH_CFG;
  assign wr_thr = reg_wr_in && reg_addr_in == OFS_MON_THR;
  assign wr_io = reg_wr_in && reg_addr_in == OFS_IO_CTRL;
  assign wr_en = reg_wr_in && reg_addr_in == OFS_OUT_EN;
  assign rd_flags = reg_rd_in && reg_addr_in == OFS_FLAGS;
  assign soft_rst = wr_en && reg_wdata_in[EN_SWRST]; // RULE14

  assign strb_act = strobe_in == io_reg[IO_STRB_POL]; // RULE13
  assign strb_rise = strb_act && !strb_act_reg;
  assign tx_act = io_reg[IO_TX_EN] && (tx_in == io_reg[IO_TX_POL]); // RULE9
  assign tx_event = tx_act && !tx_act_reg; // RULE9

  always_comb begin
    flag_set = 8'h00;
    flag_set[FLG_BL_OVP] = bl_ovp_fault_in && io_reg[IO_BL_REPORT]; // RULE2
    flag_set[FLG_BL_SHORT] = bl_short_in && io_reg[IO_BL_REPORT]; // RULE2
    flag_set[FLG_FL_OVP] = fl_ovp_fault_in; // RULE10
    flag_set[FLG_FL_OUT_SHORT] = fl_out_short_in; // RULE10
    flag_set[FLG_FL_SHORT] = fl_led_short_in; // RULE10
    flag_set[FLG_THERMAL] = thermal_in; // RULE10
    flag_set[FLG_MON] = io_reg[IO_MON_EN] && supply_below_in; // RULE8
    flag_set[FLG_TX] = tx_event; // RULE9
  end

  flash_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .start_in(fire_start),
    .stop_in(fire_stop),
    .code_in(cfg_reg[TIMEOUT_CODE_W-1:0]),
    .done_out(timer_done),
    .running_out()
  );

  // Flash sequencer; strobe mode waits for a fresh active edge
  always_comb begin
    state_next = state_reg;
    fire_start = 1'b0;
    fire_stop = 1'b0;
    flash_end = 1'b0;
    case (state_reg)
      FL_IDLE: begin
        if (en_reg[EN_FLASH]) begin
          if (en_reg[EN_FLASH_SEL]) begin // RULE14
            if (!io_reg[IO_STRB_EN] || strb_rise) begin // RULE13
              state_next = FL_FIRE;
              fire_start = 1'b1;
            end
          end else begin
            state_next = FL_TORCH;
          end
        end
      end
      FL_FIRE: begin
        if (timer_done || (io_reg[IO_STRB_EN] && !strb_act) || !en_reg[EN_FLASH]) begin
          state_next = FL_IDLE;
          fire_stop = 1'b1;
          flash_end = 1'b1; // RULE11
        end
      end
      FL_TORCH: begin
        if (!en_reg[EN_FLASH] || en_reg[EN_FLASH_SEL]) begin
          state_next = FL_IDLE;
        end
      end
      default: begin
        state_next = FL_IDLE;
      end
    endcase
    if (soft_rst) begin
      state_next = FL_IDLE;
      fire_stop = 1'b1;
    end
  end

  // Register file
  always_comb begin
    cfg_next = cfg_reg;
    thr_next = thr_reg;
    io_next = io_reg;
    en_next = en_reg;
    flags_next = flags_reg;
    rdata_next = rdata_reg;
    if (wr_cfg && !en_reg[EN_FLASH]) begin // RULE12
      cfg_next = reg_wdata_in;
    end
    if (wr_thr) begin
      thr_next = reg_wdata_in & MON_THR_MASK; // RULE3
    end
    if (wr_io) begin
      io_next = reg_wdata_in;
    end
    if (flash_end) begin
      en_next[EN_FLASH] = 1'b0; // RULE11
    end
    // A host write in the end cycle is a new request, so it wins
    if (wr_en) begin
      en_next = reg_wdata_in & OUT_EN_WR_MASK; // RULE4 RULE5 RULE14
    end
    if (rd_flags) begin
      flags_next = 8'h00;
    end
    // Set beats clear-on-read so no fault is lost
    flags_next = flags_next | flag_set; // RULE10
    if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_FLASH_CFG: rdata_next = cfg_reg;
        OFS_MON_THR: rdata_next = thr_reg;
        OFS_IO_CTRL: rdata_next = io_reg;
        OFS_OUT_EN: rdata_next = en_reg;
        OFS_FLAGS: rdata_next = flags_reg;
        default: rdata_next = 8'h00;
      endcase
    end
    if (soft_rst) begin
      cfg_next = RST_FLASH_CFG; // RULE14
      thr_next = RST_MON_THR;
      io_next = RST_IO_CTRL;
      en_next = RST_OUT_EN;
      flags_next = RST_FLAGS;
    end
  end

  always_comb begin
    strb_act_next = strb_act;
    tx_act_next = tx_act;
    pwm_next = io_reg[IO_PWM_EN] ? pwm_in : 1'b1; // RULE13
    mon_hit_next = io_reg[IO_MON_EN] && supply_below_in; // RULE3
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_reg <= RST_FLASH_CFG;
      thr_reg <= RST_MON_THR;
      io_reg <= RST_IO_CTRL;
      en_reg <= RST_OUT_EN;
      flags_reg <= RST_FLAGS;
      rdata_reg <= 8'h00;
      state_reg <= FL_IDLE;
      strb_act_reg <= 1'b0;
      tx_act_reg <= 1'b0;
      pwm_reg <= 1'b0;
      mon_hit_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      thr_reg <= thr_next;
      io_reg <= io_next;
      en_reg <= en_next;
      flags_reg <= flags_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      strb_act_reg <= strb_act_next;
      tx_act_reg <= tx_act_next;
      pwm_reg <= pwm_next;
      mon_hit_reg <= mon_hit_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign flash_output_one_en_out = en_reg[EN_FL_ONE]; // RULE4
  assign flash_output_two_en_out = en_reg[EN_FL_TWO]; // RULE4
  assign backlight_string_one_en_out = en_reg[EN_BL_ONE]; // RULE4
  assign backlight_string_two_en_out = en_reg[EN_BL_TWO]; // RULE4
  assign backlight_boost_en_out = en_reg[EN_BL_BOOST]; // RULE5
  assign flash_fire_out = state_reg == FL_FIRE;
  assign torch_on_out = state_reg == FL_TORCH;
  assign tx_active_out = tx_act_reg;
  assign pwm_out = pwm_reg;
  assign monitor_standby_out = mon_hit_reg && io_reg[IO_MON_STBY]; // RULE3
  assign monitor_torch_out = mon_hit_reg && !io_reg[IO_MON_STBY]; // RULE3
  assign threshold_code_out = thr_reg[THR_CODE_W-1:0];
  assign flash_cfg_out = cfg_reg;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_fire_end;
    state_reg == FL_FIRE ##1 state_reg == FL_IDLE;
  endsequence

  sequence s_en_write;
    wr_en && !reg_wdata_in[EN_SWRST];
  endsequence

  property p_flash_self_clear;
    s_fire_end |-> !en_reg[EN_FLASH] || $past(wr_en);
  endproperty
  a_flash_self_clear: assert property (p_flash_self_clear) else $error("flash enable kept"); // RULE11

  property p_cfg_locked;
    wr_cfg && en_reg[EN_FLASH] |=> $stable(cfg_reg);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("config written in flash"); // RULE12

  property p_bl_report_off;
    !io_reg[IO_BL_REPORT] && !flags_reg[FLG_BL_OVP] |=> !flags_reg[FLG_BL_OVP];
  endproperty
  a_bl_report_off: assert property (p_bl_report_off) else $error("ovp flag unreported"); // RULE2

  property p_mon_flag;
    io_reg[IO_MON_EN] && supply_below_in && !soft_rst |=> flags_reg[FLG_MON];
  endproperty
  a_mon_flag: assert property (p_mon_flag) else $error("monitor flag missed"); // RULE8

  property p_tx_flag;
    tx_act && !tx_act_reg && !soft_rst |=> flags_reg[FLG_TX] && tx_act_reg;
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("tx flag missed"); // RULE9

  property p_fault_flag;
    thermal_in && !soft_rst |=> flags_reg[FLG_THERMAL];
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("thermal flag missed"); // RULE10

  property p_out_en;
    s_en_write |=> flash_output_one_en_out == $past(reg_wdata_in[EN_FL_ONE])
      && backlight_string_two_en_out == $past(reg_wdata_in[EN_BL_TWO]);
  endproperty
  a_out_en: assert property (p_out_en) else $error("output enable wrong"); // RULE4

  property p_boost;
    s_en_write |=> backlight_boost_en_out == $past(reg_wdata_in[EN_BL_BOOST]);
  endproperty
  a_boost: assert property (p_boost) else $error("boost enable wrong"); // RULE5

  property p_soft_rst;
    soft_rst |=> cfg_reg == RST_FLASH_CFG && io_reg == RST_IO_CTRL && !en_reg[EN_SWRST];
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("software reset incomplete"); // RULE14

  property p_strobe_fire;
    state_reg == FL_IDLE && en_reg[EN_FLASH] && en_reg[EN_FLASH_SEL] && io_reg[IO_STRB_EN]
      && strb_rise && !soft_rst |=> state_reg == FL_FIRE;
  endproperty
  a_strobe_fire: assert property (p_strobe_fire) else $error("strobe did not fire"); // RULE13

  property p_thr_mask;
    thr_reg[7:3] == 5'h00;
  endproperty
  a_thr_mask: assert property (p_thr_mask) else $error("threshold high bits set"); // RULE3
endmodule

// >>> inc/flash_backlight_pkg.sv
package flash_backlight_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int TIMEOUT_STEP_MS = 32;
  localparam int TIMEOUT_STEP_CYCLES = TIMEOUT_STEP_MS * (CLK_HZ / 1000);
  localparam int STEP_CNT_W = 19;
  localparam int TIMEOUT_CODE_W = 5;
  localparam int THR_CODE_W = 3;

  localparam logic [7:0] OFS_FLASH_CFG = 8'h07;
  localparam logic [7:0] OFS_MON_THR = 8'h08;
  localparam logic [7:0] OFS_IO_CTRL = 8'h09;
  localparam logic [7:0] OFS_OUT_EN = 8'h0A;
  localparam logic [7:0] OFS_FLAGS = 8'h0B;

  localparam logic [7:0] RST_FLASH_CFG = 8'h4F;
  localparam logic [7:0] RST_MON_THR = 8'h00;
  localparam logic [7:0] RST_IO_CTRL = 8'h00;
  localparam logic [7:0] RST_OUT_EN = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] MON_THR_MASK = 8'h07;
  localparam logic [7:0] OUT_EN_WR_MASK = 8'h7F;

  localparam int IO_MON_EN = 0;
  localparam int IO_MON_STBY = 1;
  localparam int IO_TX_EN = 2;
  localparam int IO_TX_POL = 3;
  localparam int IO_STRB_EN = 4;
  localparam int IO_STRB_POL = 5;
  localparam int IO_PWM_EN = 6;
  localparam int IO_BL_REPORT = 7;

  localparam int EN_BL_BOOST = 0;
  localparam int EN_FLASH = 1;
  localparam int EN_FLASH_SEL = 2;
  localparam int EN_BL_TWO = 3;
  localparam int EN_BL_ONE = 4;
  localparam int EN_FL_TWO = 5;
  localparam int EN_FL_ONE = 6;
  localparam int EN_SWRST = 7;

  localparam int FLG_THERMAL = 0;
  localparam int FLG_BL_SHORT = 1;
  localparam int FLG_FL_SHORT = 2;
  localparam int FLG_TX = 3;
  localparam int FLG_MON = 4;
  localparam int FLG_FL_OUT_SHORT = 5;
  localparam int FLG_FL_OVP = 6;
  localparam int FLG_BL_OVP = 7;

  typedef enum logic [1:0] {FL_IDLE, FL_FIRE, FL_TORCH} flash_state_e;

endpackage

// >>> hdl/flash_timer.sv
`timescale 1ns/1ps
module flash_timer #(
  parameter int STEP_CYCLES = flash_backlight_pkg::TIMEOUT_STEP_CYCLES
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [flash_backlight_pkg::TIMEOUT_CODE_W-1:0] code_in,
  output logic done_out,
  output logic running_out
);
  import flash_backlight_pkg::*;

  localparam logic [STEP_CNT_W-1:0] PRE_LAST = STEP_CNT_W'(STEP_CYCLES - 1);

  logic run_reg, run_next;
  logic done_reg, done_next;
  logic [STEP_CNT_W-1:0] pre_reg, pre_next;
  logic [TIMEOUT_CODE_W-1:0] step_reg, step_next;

  // Length is (code + 1) steps of 32 ms
  always_comb begin
    run_next = run_reg;
    pre_next = pre_reg;
    step_next = step_reg;
    done_next = 1'b0;
    if (start_in) begin
      run_next = 1'b1;
      pre_next = '0;
      step_next = '0;
    end else if (stop_in) begin
      run_next = 1'b0;
    end else if (run_reg) begin
      if (pre_reg == PRE_LAST) begin
        pre_next = '0;
        if (step_reg == code_in) begin // RULE1
          run_next = 1'b0;
          done_next = 1'b1;
        end else begin
          step_next = step_reg + 5'h01;
        end
      end else begin
        pre_next = pre_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_reg <= 1'b0;
      done_reg <= 1'b0;
      pre_reg <= '0;
      step_reg <= '0;
    end else begin
      run_reg <= run_next;
      done_reg <= done_next;
      pre_reg <= pre_next;
      step_reg <= step_next;
    end
  end

  assign done_out = done_reg;
  assign running_out = run_reg;

  property p_done_exact;
    @(posedge mclk_in) disable iff (!nrst_in)
      done_reg |-> $past(step_reg) == $past(code_in) && $past(pre_reg) == PRE_LAST;
  endproperty
  a_done_exact: assert property (p_done_exact) else $error("timeout ended early"); // RULE1

  property p_step_bound;
    @(posedge mclk_in) disable iff (!nrst_in)
      run_reg && $stable(code_in) |-> step_reg <= code_in;
  endproperty
  a_step_bound: assert property (p_step_bound) else $error("step past code"); // RULE1
endmodule

// >>> verif/host_model.sv
`timescale 1ns/1ps
module host_model
  import flash_backlight_pkg::*;
(
  input wire logic mclk_in,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // One access per call; released address and data go inverted, strobes drop low, so stale values never pass
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    logic [7:0] v;
    v = d;
    if (w && a == OFS_OUT_EN && v[EN_FLASH] && !(v[EN_FL_ONE] || v[EN_FL_TWO])) begin
      v[EN_FL_ONE] = 1'b1;
    end
    if (w && a == OFS_OUT_EN && v[EN_BL_BOOST] && !(v[EN_BL_ONE] || v[EN_BL_TWO])) begin
      v[EN_BL_ONE] = 1'b1;
    end
    @(posedge mclk_in);
    reg_addr_out <= a;
    reg_wdata_out <= v;
    reg_wr_out <= w;
    reg_rd_out <= ~w;
    @(posedge mclk_in);
    reg_wr_out <= 1'b0;
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~v;
  endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import flash_backlight_pkg::*;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr, wdata, rdata, cfg;
  logic wr, rd, rd_seen = 1'b0;
  logic strobe = 1'b0, tx = 1'b0, pwm = 1'b0, sup = 1'b0;
  logic [5:0] flt = 6'h00;
  logic f1, f2, b1, b2, boost, fire, torch, txa, pwmo, stby, mtorch;
  logic [2:0] thr;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h0C2B526F;
  int bad_count = 0;
  int n_checks = 0;
  int fire_n = 0;

  initial begin
    forever #50 mclk_in = ~mclk_in;
  end

  host_model host_u (.mclk_in(mclk_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr), .reg_rd_out(rd));

  // Short time-out step keeps flash runs to a few cycles
  flash_backlight_control_regs #(.STEP_CYCLES(4)) dut_u (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .strobe_in(strobe),
    .tx_in(tx), .pwm_in(pwm), .supply_below_in(sup), .bl_ovp_fault_in(flt[5]),
    .fl_ovp_fault_in(flt[4]), .fl_out_short_in(flt[3]), .fl_led_short_in(flt[2]),
    .bl_short_in(flt[1]), .thermal_in(flt[0]), .flash_output_one_en_out(f1),
    .flash_output_two_en_out(f2), .backlight_string_one_en_out(b1),
    .backlight_string_two_en_out(b2), .backlight_boost_en_out(boost),
    .flash_fire_out(fire), .torch_on_out(torch), .tx_active_out(txa), .pwm_out(pwmo),
    .monitor_standby_out(stby), .monitor_torch_out(mtorch),
    .threshold_code_out(thr), .flash_cfg_out(cfg));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t output %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host_u.access(a, d, 1'b1);
    @(negedge mclk_in);
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.access(a, 8'h00, 1'b0);
  endtask

  task automatic fault(input logic [5:0] v, input logic s);
    @(posedge mclk_in);
    flt <= v;
    sup <= s;
    @(posedge mclk_in);
    flt <= 6'h00;
    sup <= 1'b0;
    @(negedge mclk_in);
  endtask

  // Read data is judged one edge after the strobe, against the oldest note
  always @(posedge mclk_in) begin
    rd_seen <= rd;
    if (fire === 1'b1) begin
      fire_n <= fire_n + 1;
    end
  end
  always @(negedge mclk_in) begin
    if (rd_seen) begin
      n_checks++;
      if (exp_q.size() == 0 || rdata !== exp_q[0]) begin
        bad_count++;
        $display("MISMATCH t=%0t read data %h", $time, rdata);
      end
      if (exp_q.size() > 0) begin
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge mclk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd_exp(OFS_FLASH_CFG + i[7:0], (i == 0) ? RST_FLASH_CFG : 8'h00);
    end
    rd_exp(8'h00, 8'h00);
    cmp_out(cfg, RST_FLASH_CFG);
    seed = lfsr(seed);
    wr_reg(OFS_MON_THR, seed[7:0]);
    cmp_out({5'h00, thr}, seed[7:0] & MON_THR_MASK);
    rd_exp(OFS_MON_THR, seed[7:0] & MON_THR_MASK);
    seed = lfsr(seed);
    wr_reg(OFS_IO_CTRL, seed[15:8]);
    rd_exp(OFS_IO_CTRL, seed[15:8]);
    for (int p = 0; p < 2; p++) begin
      wr_reg(OFS_IO_CTRL, {1'b0, p[0], 6'h00});
      @(posedge mclk_in);
      @(negedge mclk_in);
      cmp_out({7'h00, pwmo}, {7'h00, ~p[0]});
    end
    wr_reg(OFS_OUT_EN, 8'h79);
    cmp_out({1'b0, f1, f2, b1, b2, 2'b00, boost}, 8'h79);
    wr_reg(OFS_OUT_EN, 8'h00);
    $display("test registers done");
    wr_reg(OFS_FLAGS, 8'hFF);
    rd_exp(OFS_FLAGS, 8'h00);
    wr_reg(OFS_IO_CTRL, 8'h00);
    fault(6'h3F, 1'b1);
    rd_exp(OFS_FLAGS, 8'h65);
    rd_exp(OFS_FLAGS, 8'h00);
    wr_reg(OFS_IO_CTRL, 8'h83);
    fault(6'h3F, 1'b1);
    cmp_out({6'h00, stby, mtorch}, 8'h02);
    rd_exp(OFS_FLAGS, 8'hF7);
    for (int p = 1; p >= 0; p--) begin
      wr_reg(OFS_IO_CTRL, {4'h0, p[0], 3'h4});
      @(posedge mclk_in);
      tx <= p[0];
      @(posedge mclk_in);
      @(negedge mclk_in);
      cmp_out({7'h00, txa}, 8'h01);
      rd_exp(OFS_FLAGS, 8'h08);
    end
    wr_reg(OFS_IO_CTRL, 8'h00);
    $display("test flags done");
    wr_reg(OFS_FLASH_CFG, 8'h41);
    fire_n = 0;
    wr_reg(OFS_OUT_EN, 8'h66);
    wr_reg(OFS_FLASH_CFG, 8'h5F);
    repeat (20) @(posedge mclk_in);
    cmp_out({7'h00, fire_n >= 8 && fire_n <= 10}, 8'h01);
    rd_exp(OFS_OUT_EN, 8'h64);
    rd_exp(OFS_FLASH_CFG, 8'h41);
    wr_reg(OFS_OUT_EN, 8'h62);
    @(posedge mclk_in);
    @(negedge mclk_in);
    cmp_out({6'h00, torch, fire}, 8'h02);
    wr_reg(OFS_OUT_EN, 8'h80);
    rd_exp(OFS_OUT_EN, 8'h00);
    rd_exp(OFS_FLASH_CFG, RST_FLASH_CFG);
    cmp_out({7'h00, torch}, 8'h00);
    $display("test flash done");
    wr_reg(OFS_IO_CTRL, 8'h30);
    wr_reg(OFS_OUT_EN, 8'h66);
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    cmp_out({7'h00, fire}, 8'h00);
    @(posedge mclk_in);
    strobe <= 1'b1;
    @(posedge mclk_in);
    @(negedge mclk_in);
    cmp_out({7'h00, fire}, 8'h01);
    @(posedge mclk_in);
    strobe <= 1'b0;
    rd_exp(OFS_OUT_EN, 8'h64);
    wr_reg(OFS_IO_CTRL, 8'h01);
    fault(6'h00, 1'b1);
    cmp_out({6'h00, stby, mtorch}, 8'h01);
    $display("test strobe done");
    repeat (3) @(posedge mclk_in);
    report_and_stop();
  end
endmodule
